// ### src/pwm_front_regs.vh
// Register indices, field positions, reset values and APB timing of the PWM clock front end
`ifndef PWM_FRONT_REGS_VH
`define PWM_FRONT_REGS_VH
// Register indices; byte address on APB is four times the index
`define IDX_CLOCK_PRESCALE_CONCAT 8'h40
`define IDX_CLOCK_SELECT_POLARITY 8'h41
`define IDX_CHANNEL_ENABLE        8'h42
`define IDX_PRESCALE_COUNTER      8'h43
`define IDX_SCALE_VALUE_0         8'h44
`define IDX_SCALE_DOWN_COUNT_0    8'h45
`define IDX_SPECIAL_TEST_REG      8'h55
// Field positions
`define FLD_JOIN_UPPER_PAIR       7
`define FLD_JOIN_LOWER_PAIR       6
`define FLD_FIRST_PRESCALE_HI     5
`define FLD_FIRST_PRESCALE_LO     3
`define FLD_SECOND_PRESCALE_HI    2
`define FLD_SECOND_PRESCALE_LO    0
`define FLD_SCALED_SEL_LO         4
`define FLD_START_HIGH_LO         0
`define FLD_BLOCK_SCALE_RELOAD    5
// Reset values
`define RST_CLOCK_PRESCALE_CONCAT 8'h00
`define RST_CLOCK_SELECT_POLARITY 8'h00
`define RST_CHANNEL_ENABLE        4'h0
`define RST_PRESCALE_COUNTER      7'h00
`define RST_SCALE_VALUE_0         8'h00
`define RST_SPECIAL_TEST_REG      1'b0
// APB timing: cycles from the first access edge to pready
`define APB_WAIT_CYCLES           1
`endif

// ### src/scale_divider.v
// Scaled clock generator: reloading down-counter plus final divide by two
`default_nettype none
module scale_divider (
  input  wire       clock_i,
  input  wire       rst_i,
  input  wire       src_tick_i,
  input  wire [7:0] scale_value_i,
  input  wire       load_i,
  output wire [7:0] count_o,
  output wire       scaled_tick_o
);
  reg [7:0] count_ff;
  reg       level_ff;
  wire      at_zero;

  assign at_zero = (count_ff == 8'h00);
  assign count_o = count_ff;
  // Rising edge of the scaled clock: one source tick per 2 x (scale + 1)
  assign scaled_tick_o = src_tick_i & at_zero & ~level_ff;

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      count_ff <= 8'h00;
      level_ff <= 1'b0;
    end else if (load_i) begin
      count_ff <= scale_value_i;
    end else if (src_tick_i) begin
      if (at_zero) begin
        count_ff <= scale_value_i;
        level_ff <= ~level_ff;
      end else begin
        count_ff <= count_ff - 8'h01;
      end
    end
  end
endmodule // scale_divider
`default_nettype wire

// ### src/channel_gate.v
// One channel: edge-synchronised clock gate and left-aligned output level
`default_nettype none
module channel_gate (
  input  wire clock_i,
  input  wire rst_i,
  input  wire enable_i,
  input  wire src_tick_i,
  input  wire start_high_i,
  input  wire period_start_i,
  input  wire duty_match_i,
  output wire active_o,
  output wire chan_tick_o,
  output wire wave_o
);
  reg active_ff;
  reg wave_ff;

  assign active_o    = active_ff;
  // Gate opens only on a tick of the selected source, so no partial tick
  assign chan_tick_o = src_tick_i & active_ff;
  assign wave_o      = wave_ff;

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      active_ff <= 1'b0;
      wave_ff   <= 1'b0;
    end else begin
      // Closing at once cannot cut a one-cycle tick, and keeps the gate from
      // staying open while the prescaler is stopped
      if (src_tick_i | ~enable_i) begin
        active_ff <= enable_i;
      end
      if (active_ff & period_start_i) begin
        wave_ff <= start_high_i;
      end else if (active_ff & duty_match_i) begin
        wave_ff <= ~start_high_i;
      end else if (~active_ff) begin
        wave_ff <= start_high_i;
      end
    end
  end
endmodule // channel_gate
`default_nettype wire

// ### src/pwm_clock_select_and_enable.v
// PWM clock front end: prescalers, scaled clocks, channel gating, pin takeover, APB registers
//
// The APB interface to the registers was decided locally.
`include "pwm_front_regs.vh"
`default_nettype none
module pwm_clock_select_and_enable (
  input  wire        clock_i,
  input  wire        rst_i,
  // APB slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [9:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  // Chip mode, from logic on the same clock
  input  wire        special_mode_flag_i,
  // Scaled clock B path from the neighbouring scaler 1
  input  wire        scaled_tick_1_i,
  // Events from the channel counters
  input  wire [3:0]  period_start_i,
  input  wire [3:0]  duty_match_i,
  // General-purpose port side
  input  wire [3:0]  pin_direction_bits_i,
  input  wire [3:0]  port_data_i,
  input  wire [3:0]  pin_i,
  // Outputs
  output wire [3:0]  pin_o,
  output wire [3:0]  pin_oe_o,
  output wire [3:0]  pin_level_o,
  output wire [3:0]  chan_tick_o,
  output wire        clock_b_tick_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  // Divide-by-two-to-the-code tick from the shared prescaler count
  function prescale_tick;
    input [6:0] count;
    input [2:0] code;
    reg   [6:0] mask;
    begin
      mask          = (7'h7f >> (3'd7 - code));
      prescale_tick = ((count & mask) == mask);
    end
  endfunction

  // Write strobe of one register: a committed write that hits its index
  function reg_write;
    input       commit;
    input [7:0] index;
    input [7:0] target;
    begin
      reg_write = commit && (index == target);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg  [7:0]  clock_prescale_concat_ff;
  reg  [7:0]  clock_select_polarity_ff;
  reg  [3:0]  channel_on_bit_ff;
  reg  [6:0]  prescale_counter_ff;
  reg  [7:0]  scale_value_0_ff;
  reg         block_scale_reload_ff;
  reg  [31:0] prdata_ff;
  reg         pready_ff;
  reg         pslverr_ff;
  reg  [31:0] nxt_prdata;
  reg         nxt_pslverr;

  wire [7:0]  reg_index;
  wire        addr_ok;
  wire        wr_commit;
  wire        rd_take;
  wire [7:0]  scale_down_count_0;

  assign reg_index = paddr_i[9:2];
  assign addr_ok   = (paddr_i[1:0] == 2'b00) &&
                     ((reg_index == `IDX_CLOCK_PRESCALE_CONCAT) ||
                      (reg_index == `IDX_CLOCK_SELECT_POLARITY) ||
                      (reg_index == `IDX_CHANNEL_ENABLE) ||
                      (reg_index == `IDX_PRESCALE_COUNTER) ||
                      (reg_index == `IDX_SCALE_VALUE_0) ||
                      (reg_index == `IDX_SCALE_DOWN_COUNT_0) ||
                      (reg_index == `IDX_SPECIAL_TEST_REG));
  // One wait state: pready rises on the edge after the first access edge
  assign rd_take   = psel_i & penable_i & ~pready_ff;
  assign wr_commit = psel_i & penable_i & pready_ff & pwrite_i & addr_ok;

  assign prdata_o  = prdata_ff;
  assign pready_o  = pready_ff;
  assign pslverr_o = pslverr_ff;

  always @* begin
    nxt_prdata  = 32'h0000_0000;
    nxt_pslverr = ~addr_ok;
    case (reg_index)
      `IDX_CLOCK_PRESCALE_CONCAT: nxt_prdata[7:0] = clock_prescale_concat_ff;
      `IDX_CLOCK_SELECT_POLARITY: nxt_prdata[7:0] = clock_select_polarity_ff;
      `IDX_CHANNEL_ENABLE:        nxt_prdata[3:0] = channel_on_bit_ff;
      `IDX_PRESCALE_COUNTER:      nxt_prdata[6:0] = prescale_counter_ff;
      `IDX_SCALE_VALUE_0:         nxt_prdata[7:0] = scale_value_0_ff;
      `IDX_SCALE_DOWN_COUNT_0:    nxt_prdata[7:0] = scale_down_count_0;
      `IDX_SPECIAL_TEST_REG:
        nxt_prdata[`FLD_BLOCK_SCALE_RELOAD] = block_scale_reload_ff;
      default:                    nxt_prdata = 32'h0000_0000;
    endcase
    if (pwrite_i | ~addr_ok) begin
      nxt_prdata = 32'h0000_0000;
    end
  end

  // Read data and error stand for the single pready cycle and are zero otherwise
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff <= rd_take;
      if (rd_take) begin
        prdata_ff  <= nxt_prdata;
        pslverr_ff <= nxt_pslverr;
      end else begin
        prdata_ff  <= 32'h0000_0000;
        pslverr_ff <= 1'b0;
      end
    end
  end

  wire scale_0_write;
  assign scale_0_write = reg_write(wr_commit, reg_index, `IDX_SCALE_VALUE_0);

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      clock_prescale_concat_ff <= `RST_CLOCK_PRESCALE_CONCAT;
      clock_select_polarity_ff <= `RST_CLOCK_SELECT_POLARITY;
      channel_on_bit_ff        <= `RST_CHANNEL_ENABLE;
      scale_value_0_ff         <= `RST_SCALE_VALUE_0;
      block_scale_reload_ff    <= `RST_SPECIAL_TEST_REG;
    end else begin
      if (reg_write(wr_commit, reg_index, `IDX_CLOCK_PRESCALE_CONCAT)) begin
        clock_prescale_concat_ff <= pwdata_i[7:0];
      end
      if (reg_write(wr_commit, reg_index, `IDX_CLOCK_SELECT_POLARITY)) begin
        clock_select_polarity_ff <= pwdata_i[7:0];
      end
      if (reg_write(wr_commit, reg_index, `IDX_CHANNEL_ENABLE)) begin
        channel_on_bit_ff <= pwdata_i[3:0];
      end
      if (scale_0_write) begin
        scale_value_0_ff <= pwdata_i[7:0];
      end
      // Test bits exist only in special mode and clear themselves outside it
      if (~special_mode_flag_i) begin
        block_scale_reload_ff <= 1'b0;
      end else if (reg_write(wr_commit, reg_index, `IDX_SPECIAL_TEST_REG)) begin
        block_scale_reload_ff <= pwdata_i[`FLD_BLOCK_SCALE_RELOAD];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared prescaler and clocks A and B
  wire       prescale_run;
  wire       prescale_write;
  wire [2:0] first_prescale_code;
  wire [2:0] second_prescale_code;
  wire       clock_a_tick;
  wire       clock_b_tick;
  reg        clock_b_tick_ff;

  assign first_prescale_code  =
    clock_prescale_concat_ff[`FLD_FIRST_PRESCALE_HI:`FLD_FIRST_PRESCALE_LO];
  assign second_prescale_code =
    clock_prescale_concat_ff[`FLD_SECOND_PRESCALE_HI:`FLD_SECOND_PRESCALE_LO];
  // Saves power: nothing downstream moves while every channel is off
  assign prescale_run   = |channel_on_bit_ff;
  assign prescale_write = reg_write(wr_commit, reg_index, `IDX_PRESCALE_COUNTER) &&
                          special_mode_flag_i;
  assign clock_a_tick = prescale_run &
                        prescale_tick(prescale_counter_ff, first_prescale_code);
  assign clock_b_tick = prescale_run &
                        prescale_tick(prescale_counter_ff, second_prescale_code);

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      prescale_counter_ff <= `RST_PRESCALE_COUNTER;
      clock_b_tick_ff     <= 1'b0;
    end else begin
      clock_b_tick_ff <= clock_b_tick;
      if (prescale_write) begin
        prescale_counter_ff <= pwdata_i[6:0];
      end else if (prescale_run) begin
        prescale_counter_ff <= prescale_counter_ff + 7'h01;
      end
    end
  end
  // Clock B is handed to the neighbouring scaler 1, which returns S1
  assign clock_b_tick_o = clock_b_tick_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Scaled clock S0
  wire       scaled_tick_0;
  wire       scale_0_load;
  wire [7:0] scale_0_src;

  // A write loads the counter with bus data unless block_scale_reload_ff is set in special mode; every later reload takes the held
  // scale value, so the counter never picks up unrelated bus traffic
  assign scale_0_load = scale_0_write &
                        ~(special_mode_flag_i & block_scale_reload_ff);
  assign scale_0_src  = scale_0_load ? pwdata_i[7:0] : scale_value_0_ff;

  scale_divider u_scale_0 (
    .clock_i       (clock_i),
    .rst_i         (rst_i),
    .src_tick_i    (clock_a_tick),
    .scale_value_i (scale_0_src),
    .load_i        (scale_0_load),
    .count_o       (scale_down_count_0),
    .scaled_tick_o (scaled_tick_0)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Channel clock selection, concatenation and gating
  // Events of a joined pair arrive on the high-byte channel, ch0 or ch2
  wire [3:0] scaled_sel;
  wire [3:0] own_src;
  wire [3:0] src_tick;
  wire [3:0] gated_tick;
  wire [3:0] wave;
  wire [3:0] active;
  wire       join_upper_pair;
  wire       join_lower_pair;

  assign scaled_sel      = clock_select_polarity_ff[`FLD_SCALED_SEL_LO +: 4];
  assign join_upper_pair = clock_prescale_concat_ff[`FLD_JOIN_UPPER_PAIR];
  assign join_lower_pair = clock_prescale_concat_ff[`FLD_JOIN_LOWER_PAIR];

  // A changed select takes effect at once, which may cut one pulse short
  assign own_src[0] = scaled_sel[0] ? scaled_tick_0 : clock_a_tick;
  assign own_src[1] = scaled_sel[1] ? scaled_tick_0 : clock_a_tick;
  assign own_src[2] = scaled_sel[2] ? scaled_tick_1_i : clock_b_tick;
  assign own_src[3] = scaled_sel[3] ? scaled_tick_1_i : clock_b_tick;

  assign src_tick[0] = join_lower_pair ? own_src[1] : own_src[0];
  assign src_tick[1] = own_src[1];
  assign src_tick[2] = join_upper_pair ? own_src[3] : own_src[2];
  assign src_tick[3] = own_src[3];

  // One gate per channel; the low byte of a joined pair keeps its own gate
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_chan
      channel_gate u_gate (
        .clock_i        (clock_i),
        .rst_i          (rst_i),
        .enable_i       (channel_on_bit_ff[k]),
        .src_tick_i     (src_tick[k]),
        .start_high_i   (clock_select_polarity_ff[`FLD_START_HIGH_LO + k]),
        .period_start_i (period_start_i[k]),
        .duty_match_i   (duty_match_i[k]),
        .active_o       (active[k]),
        .chan_tick_o    (gated_tick[k]),
        .wave_o         (wave[k])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pin takeover and input sampling
  reg  [3:0] pin_ff;
  reg  [3:0] pin_oe_ff;
  reg  [3:0] chan_tick_ff;
  reg  [3:0] sync1_ff;
  reg  [3:0] sync2_ff;
  reg  [3:0] sync3_ff;
  reg  [3:0] pin_level_ff;
  wire [3:0] pwm_owns;
  wire [3:0] pwm_shows;

  // Low byte of a joined pair gives its pin back to the port
  assign pwm_owns  = channel_on_bit_ff &
                     ~{join_upper_pair, 1'b0, join_lower_pair, 1'b0};
  // Waveform reaches the pin only once the gate has seen a source tick
  assign pwm_shows = pwm_owns & active;

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pin_ff       <= 4'h0;
      pin_oe_ff    <= 4'h0;
      chan_tick_ff <= 4'h0;
    end else begin
      pin_ff       <= (pwm_shows & wave) | (~pwm_shows & port_data_i);
      pin_oe_ff    <= pwm_owns | pin_direction_bits_i;
      chan_tick_ff <= gated_tick;
    end
  end

  // Pin sampler: only the second and third stages feed logic, since the first may
  // still be settling from a metastable capture
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_ff     <= 4'h0;
      sync2_ff     <= 4'h0;
      sync3_ff     <= 4'h0;
      pin_level_ff <= 4'h0;
    end else begin
      sync1_ff     <= pin_i;
      sync2_ff     <= sync1_ff;
      sync3_ff     <= sync2_ff;
      // A new level counts once two stages agree; a disagreement keeps the old level
      pin_level_ff <= (sync2_ff & sync3_ff) | ((sync2_ff ^ sync3_ff) & pin_level_ff);
    end
  end

  assign pin_o       = pin_ff;
  assign pin_oe_o    = pin_oe_ff;
  assign pin_level_o = pin_level_ff;
  assign chan_tick_o = chan_tick_ff;
endmodule // pwm_clock_select_and_enable
`default_nettype wire

// ### tb/pin_loads.sv
// External loads on the shared port pins: pull-ups, optionally slow
`default_nettype none
module pin_loads #(
  parameter int SLOW = 0
) (
  input  wire logic       clock_i,
  input  wire logic [3:0] pin_o,
  input  wire logic [3:0] pin_oe_o,
  output wire logic [3:0] pin_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] slow_ff;
  // A released pin floats up, so it never keeps showing the last driven level
  wire  [3:0] level = (pin_oe_o & pin_o) | ~pin_oe_o;
  always @(posedge clock_i) begin
    slow_ff <= level;
  end
  assign pin_i = (SLOW != 0) ? slow_ff : level;
endmodule  // pin_loads
`default_nettype wire

// ### tb/pwm_front_asserts.sv
// Port-level assertions of the PWM clock front end
`default_nettype none
module pwm_front_asserts (
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [9:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [3:0]  pin_direction_bits_i,
  input wire logic [3:0]  pin_oe_o,
  input wire logic [3:0]  chan_tick_o,
  input wire logic        clock_b_tick_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] en_ff;
  logic [1:0] join_ff;
  logic [2:0] code_b_ff;
  logic [7:0] gap_ff;
  logic [1:0] seen_ff;
  logic       ever_ff;
  wire        commit = psel_i && penable_i && pready_o && pwrite_i;
  wire        cfg_wr = commit && (paddr_i inside {10'h100, 10'h108, 10'h10c});
  wire  [3:0] oe_exp = (en_ff & ~{join_ff[1], 1'b0, join_ff[0], 1'b0}) | pin_direction_bits_i;
  ////////////////////////////////////////////////////////////////////////////
  // The first clock B tick after a change may still follow the old code
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      en_ff <= 4'h0;
      join_ff <= 2'b00;
      code_b_ff <= 3'h0;
      gap_ff <= 8'h00;
      seen_ff <= 2'd0;
      ever_ff <= 1'b0;
    end else begin
      if (commit && paddr_i == 10'h100) begin
        join_ff <= pwdata_i[7:6];
        code_b_ff <= pwdata_i[2:0];
      end
      if (commit && paddr_i == 10'h108) en_ff <= pwdata_i[3:0];
      ever_ff <= ever_ff | (commit && paddr_i == 10'h108 && |pwdata_i[3:0]);
      gap_ff <= clock_b_tick_o ? 8'h01 : gap_ff + {7'h0, gap_ff != 8'hff};
      if (cfg_wr || en_ff == 4'h0) seen_ff <= 2'd0;
      else if (clock_b_tick_o && seen_ff != 2'd2) seen_ff <= seen_ff + 2'd1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_ready_resp;
    psel_i && penable_i && !pready_o |=> pready_o;
  endproperty
  property p_ready_pulse;
    pready_o |=> !pready_o;
  endproperty
  property p_rdata_idle;
    !pready_o |-> prdata_o == 32'h0;
  endproperty
  property p_err_misalign;
    psel_i && penable_i && !pready_o && paddr_i[1:0] != 2'b00 |=> pslverr_o;
  endproperty
  property p_err_read_zero;
    pslverr_o |-> prdata_o == 32'h0;
  endproperty
  property p_oe_map;
    !$past(rst_i) |-> pin_oe_o == $past(oe_exp);
  endproperty
  property p_clock_b_rate;
    clock_b_tick_o && seen_ff == 2'd2 |-> gap_ff == (8'h01 << code_b_ff);
  endproperty
  property p_idle_quiet;
    !ever_ff |-> chan_tick_o == 4'h0;
  endproperty
  a_ready_resp:    assert property (p_ready_resp) else $error("pready late");
  a_ready_pulse:   assert property (p_ready_pulse) else $error("pready too long");
  a_rdata_idle:    assert property (p_rdata_idle) else $error("prdata not zero");
  a_err_misalign:  assert property (p_err_misalign) else $error("no pslverr");
  a_err_read_zero: assert property (p_err_read_zero) else $error("error read not 0");
  a_oe_map:        assert property (p_oe_map) else $error("pin_oe_o wrong");
  a_clock_b_rate:  assert property (p_clock_b_rate) else $error("clock B rate");
  a_idle_quiet:    assert property (p_idle_quiet) else $error("tick while idle");
  c_enable_write:  cover property (commit && paddr_i == 10'h108);
  c_rate_checked:  cover property (clock_b_tick_o && seen_ff == 2'd2);
  c_slverr:        cover property (pready_o && pslverr_o);
endmodule  // pwm_front_asserts
bind pwm_clock_select_and_enable pwm_front_asserts chk_u (
  .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .pin_oe_o(pin_oe_o),
  .pin_direction_bits_i(pin_direction_bits_i), .chan_tick_o(chan_tick_o),
  .clock_b_tick_o(clock_b_tick_o)
);
`default_nettype wire

// ### tb/pwm_clock_select_and_enable_tb.sv
// Self-checking bench of the PWM clock front end
`default_nettype none
module pwm_clock_select_and_enable_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
  logic        pwrite_i = 1'b0, special_mode_flag_i = 1'b0, scaled_tick_1_i = 1'b0;
  logic [9:0]  paddr_i = 10'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0]  period_start_i = 4'h0, duty_match_i = 4'h0;
  logic [3:0]  pin_direction_bits_i = 4'h0, port_data_i = 4'h0;
  wire  [31:0] prdata_o;
  wire         pready_o, pslverr_o, clock_b_tick_o;
  wire  [3:0]  pin_i, pin_o, pin_oe_o, pin_level_o, chan_tick_o;
  logic [33:0] expq[$];
  logic [33:0] note;
  logic [9:0]  regs[7] = '{10'h100, 10'h104, 10'h108, 10'h10c, 10'h110, 10'h114, 10'h154};
  int          miscompares = 0, num_checks = 0, cycles = 0, s1_cnt = 0, k, s;

  pwm_clock_select_and_enable dut_u (
    .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .special_mode_flag_i(special_mode_flag_i),
    .scaled_tick_1_i(scaled_tick_1_i), .period_start_i(period_start_i),
    .duty_match_i(duty_match_i), .pin_direction_bits_i(pin_direction_bits_i),
    .port_data_i(port_data_i), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .pin_level_o(pin_level_o), .chan_tick_o(chan_tick_o), .clock_b_tick_o(clock_b_tick_o)
  );
  pin_loads #(.SLOW(1)) loads_u (.clock_i(clock_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .pin_i(pin_i));

  always #10 clock_i = ~clock_i;
  // Stand-in for scaler 1: one S1 rising edge every 6 cycles
  always @(posedge clock_i) begin
    s1_cnt <= (s1_cnt == 5) ? 0 : s1_cnt + 1;
    scaled_tick_1_i <= (s1_cnt == 5);
  end
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Every bus answer is held against the oldest noted expectation
  always @(posedge clock_i) begin
    if (psel_i && penable_i && pready_o === 1'b1) begin
      note = expq.pop_front();
      chk("pslverr", {31'h0, note[32]}, {31'h0, pslverr_o});
      if (!note[33]) chk("prdata", note[31:0], prdata_o);
    end
  end
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d,
                     input logic err, input logic [31:0] exp);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    expq.push_back({w, err, exp});
    @(posedge clock_i);
    penable_i <= 1'b1;
    do @(posedge clock_i); while (pready_o !== 1'b1);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic cfg(input logic [7:0] clk, input logic [7:0] sel, input logic [3:0] en);
    apb(1'b1, 10'h100, {24'h0, clk}, 1'b0, 32'h0);
    apb(1'b1, 10'h104, {24'h0, sel}, 1'b0, 32'h0);
    apb(1'b1, 10'h108, {28'h0, en}, 1'b0, 32'h0);
  endtask
  // The first ticks after a select change may be truncated the third gap counts
  task automatic gap(input int ch, input int exp);
    int n;
    repeat (3) begin
      n = 0;
      @(posedge clock_i);
      while (chan_tick_o[ch] !== 1'b1) begin
        n++;
        @(posedge clock_i);
      end
    end
    chk("tick gap", exp, n + 1);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(37));
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    pin_direction_bits_i <= 4'($urandom);
    @(posedge clock_i);
    foreach (regs[i]) apb(1'b0, regs[i], 32'h0, 1'b0, 32'h0);
    apb(1'b0, 10'h120, 32'h0, 1'b1, 32'h0);
    apb(1'b1, 10'h106, 32'hff, 1'b1, 32'h0);
    for (k = 0; k < 8; k++) begin
      cfg(8'(k << 3), 8'h00, 4'h1);
      apb(1'b0, 10'h100, 32'h0, 1'b0, 32'(k << 3));
      gap(0, 1 << k);
    end
    repeat (3) begin
      k = $urandom_range(2);
      s = $urandom_range(3);
      port_data_i <= 4'($urandom);
      apb(1'b1, 10'h110, 32'(s), 1'b0, 32'h0);
      cfg(8'(k << 3), 8'h10, 4'h1);
      gap(0, (2 << k) * (s + 1));
      cfg(8'h40 | 8'(k << 3), 8'h20, 4'h3);
      gap(0, (2 << k) * (s + 1));
      chk("gpio pin 1", {31'h0, port_data_i[1]}, {31'h0, pin_o[1]});
      cfg(8'h40 | 8'(k << 3), 8'h10, 4'h1);
      gap(0, 1 << k);
      cfg(8'(k), 8'h00, 4'h4);
      gap(2, 1 << k);
      cfg(8'(k), 8'h40, 4'h4);
      gap(2, 6);
      cfg(8'h80 | 8'(k), 8'h80, 4'hc);
      gap(2, 6);
      chk("gpio pin 3", {31'h0, port_data_i[3]}, {31'h0, pin_o[3]});
    end
    cfg(8'h00, 8'h00, 4'h1);
    for (k = 0; k < 2; k++) begin
      apb(1'b1, 10'h104, 32'(k), 1'b0, 32'h0);
      apb(1'b0, 10'h104, 32'h0, 1'b0, 32'(k));
      period_start_i <= 4'h1;
      @(posedge clock_i);
      period_start_i <= 4'h0;
      repeat (3) @(posedge clock_i);
      chk("wave start", 32'(k), {31'h0, pin_o[0]});
      duty_match_i <= 4'h1;
      @(posedge clock_i);
      duty_match_i <= 4'h0;
      repeat (8) @(posedge clock_i);
      chk("wave match", 32'(1 - k), {31'h0, pin_o[0]});
      chk("pin level", 32'(1 - k), {31'h0, pin_level_o[0]});
    end
    chk("gpio pins", {29'h0, port_data_i[3:1]}, {29'h0, pin_o[3:1]});
    apb(1'b1, 10'h108, 32'h0, 1'b0, 32'h0);
    special_mode_flag_i <= 1'b1;
    apb(1'b1, 10'h10c, 32'hd3, 1'b0, 32'h0);
    repeat (20) @(posedge clock_i);
    apb(1'b0, 10'h10c, 32'h0, 1'b0, 32'h53);
    apb(1'b1, 10'h110, 32'h9c, 1'b0, 32'h0);
    apb(1'b0, 10'h114, 32'h0, 1'b0, 32'h9c);
    apb(1'b1, 10'h154, 32'h20, 1'b0, 32'h0);
    apb(1'b1, 10'h110, 32'h41, 1'b0, 32'h0);
    apb(1'b0, 10'h114, 32'h0, 1'b0, 32'h9c);
    special_mode_flag_i <= 1'b0;
    apb(1'b1, 10'h10c, 32'h11, 1'b0, 32'h0);
    apb(1'b0, 10'h10c, 32'h0, 1'b0, 32'h53);
    apb(1'b1, 10'h110, 32'h07, 1'b0, 32'h0);
    apb(1'b0, 10'h114, 32'h0, 1'b0, 32'h07);
    conclude();
  end
endmodule  // pwm_clock_select_and_enable_tb
`default_nettype wire
